// [shared/run_ctl_pkg.sv]
// Package: constants and types for the emulation run-control block
`default_nettype none
package run_ctl_pkg;
	// --------------------------------------------------------------
	// Widths
	// --------------------------------------------------------------
	localparam int PERIOD_W = 24;  // Cycle reset period counter width
	localparam int CNT_W = 5;      // Host access unit counter width
	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;               // sys_clk period
	localparam int RESET_PULSE_NS = 100;            // Target reset and trigger pulse width
	localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HALT_PULSE_NS = 20;              // Trigger low pulse on a break
	localparam int HALT_PULSE_CYC = (HALT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// --------------------------------------------------------------
	// Host access units (bytes per target halt)
	// --------------------------------------------------------------
	localparam logic [4:0] UNIT_MEM = 5'h01;  // Memory command: each access
	localparam logic [4:0] UNIT_DUMP = 5'h10;  // Dump: 16-byte units
	localparam logic [4:0] UNIT_DIS = 5'h04;  // Disassembly: 4-byte units
	// --------------------------------------------------------------
	// Host access kinds
	// --------------------------------------------------------------
	localparam logic [1:0] ACC_MEM = 2'h0;
	localparam logic [1:0] ACC_DUMP = 2'h1;
	localparam logic [1:0] ACC_DIS = 2'h2;
	// --------------------------------------------------------------
	// Run states, one-hot
	// --------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,   // Target halted
		ST_NORMAL = 5'b00010, // Normal real-time run
		ST_CYCLE = 5'b00100,  // Cycle reset run
		ST_PAR_MULTI = 5'b01000, // Parallel, entered by return or trace stop
		ST_PAR_ONE = 5'b10000    // Parallel, entered by space
	} run_state_t;
endpackage
`default_nettype wire

// [src/emulation_run_control.sv]
// Run-control logic of an emulator pod: normal, cycle reset and parallel modes
//
// How it works
// - Real-time run never inserts target wait states.
// - Normal mode break halts, one trigger low pulse.
// - Software break halts and pulses like hardware break.
// - Run without options selects normal mode.
// - Gate mode arbitrates memories, no CS sharing.
// - Realtime mode connects bus directly, no sharing.
// - Setting disables trace capture of cache accesses.
// - Cycle reset mode resets target every period.
// - Trigger pulse coincides with target reset.
// - Run with period option enters cycle reset.
// - Cycle reset ignores breaks, only forced stop.
// - Return, space or trace stop enter parallel.
// - Return or trace stop freeze trace, many commands.
// - Terminate leaves parallel, reports PC, resumes trace.
// - Space: trace continues, one command then back.
// - Host access halts target per access unit.
// - No parallel mode during cycle reset run.
`default_nettype none
module emulation_run_control (
	input wire logic sys_clk,
	input wire logic srst,
	// Console commands (one-cycle pulses)
	input wire logic run_cmd,
	input wire logic run_period_opt,
	input wire logic [run_ctl_pkg::PERIOD_W-1:0] run_period,
	input wire logic force_stop,
	input wire logic key_return,
	input wire logic key_space,
	input wire logic terminate_cmd,
	input wire logic cmd_start,
	input wire logic cmd_is_trace,
	input wire logic cmd_done,
	input wire logic host_acc_req,
	input wire logic [1:0] host_acc_kind,
	input wire logic [4:0] host_acc_bytes,
	// Configuration levels
	input wire logic gate_mode,
	input wire logic cache_trace_dis,
	input wire logic [3:0] user_cs_map,
	input wire logic [3:0] emu_cs_map,
	// Target side events
	input wire logic hw_break,
	input wire logic sw_break,
	input wire logic trace_stop,
	input wire logic target_cache_acc,
	input wire logic target_bus_cyc,
	input wire logic [3:0] target_cs,
	input wire logic [31:0] target_pc,
	// Outputs
	output logic target_run,
	output logic target_reset_line,
	output logic trigger_out_n,
	output logic target_wait,
	output logic user_bus_sel,
	output logic emu_bus_sel,
	output logic direct_bus,
	output logic map_conflict,
	output logic trace_enable,
	output logic parallel_active,
	output logic pc_report_valid,
	output logic [31:0] pc_report,
	output logic host_acc_done
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	run_ctl_pkg::run_state_t state_reg; // Run state
	run_ctl_pkg::run_state_t state_next; // Next run state
	logic [run_ctl_pkg::PERIOD_W-1:0] period_reg; // Programmed reset interval
	logic [run_ctl_pkg::PERIOD_W-1:0] tick_reg; // Cycle reset elapsed count
	logic [7:0] rst_cnt_reg; // Target reset pulse remaining
	logic [7:0] trg_cnt_reg; // Trigger low remaining
	logic trace_frozen_reg; // Trace stopped by return or trace stop entry
	logic trace_cmd_reg; // Trace command in progress
	logic one_cmd_seen_reg; // Space mode command started
	logic [4:0] acc_left_reg; // Bytes left in host access
	logic [4:0] unit_left_reg; // Bytes left in current unit
	logic acc_busy_reg; // Host access in progress
	logic [4:0] acc_unit_reg; // Unit size latched with the request, so the kind input may move
	logic halt_pulse; // Halting break this cycle
	logic period_hit; // Cycle reset period elapsed
	logic running; // Any run state
	logic par_enter; // Parallel entry request
	logic [4:0] unit_size; // Bytes per halt for this access
	logic conflict; // Chip-select area shared
	logic freeze_now; // Return or trace stop entry this cycle

	assign running = (state_reg != run_ctl_pkg::ST_IDLE);
	// In cycle reset mode breaks are masked entirely
	assign halt_pulse = (state_reg == run_ctl_pkg::ST_NORMAL) && (hw_break || sw_break);
	assign period_hit = (state_reg == run_ctl_pkg::ST_CYCLE) && (tick_reg >= period_reg);
	assign par_enter = (key_return || key_space || trace_stop);
	assign freeze_now = (state_reg == run_ctl_pkg::ST_NORMAL) && (state_next == run_ctl_pkg::ST_PAR_MULTI);
	// Both memories in one area is illegal in either bus mode
	assign conflict = |(user_cs_map & emu_cs_map);

	// ----------------------------------------------------------------
	// Host access unit size
	// ----------------------------------------------------------------
	always_comb begin
		case (host_acc_kind)
			run_ctl_pkg::ACC_DUMP: begin
				unit_size = run_ctl_pkg::UNIT_DUMP;
			end
			run_ctl_pkg::ACC_DIS: begin
				unit_size = run_ctl_pkg::UNIT_DIS;
			end
			default: begin
				unit_size = run_ctl_pkg::UNIT_MEM;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Run state machine
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			run_ctl_pkg::ST_IDLE: begin
				// Plain run picks normal, period option picks cycle reset
				if (run_cmd && run_period_opt) begin
					state_next = run_ctl_pkg::ST_CYCLE;
				end else if (run_cmd) begin
					state_next = run_ctl_pkg::ST_NORMAL;
				end
			end
			run_ctl_pkg::ST_NORMAL: begin
				// Forced stop and breaks halt; parallel keeps running
				if (force_stop || halt_pulse) begin
					state_next = run_ctl_pkg::ST_IDLE;
				end else if (key_space) begin
					state_next = run_ctl_pkg::ST_PAR_ONE;
				end else if (par_enter) begin
					state_next = run_ctl_pkg::ST_PAR_MULTI;
				end
			end
			run_ctl_pkg::ST_CYCLE: begin
				// Parallel keys and breaks are refused here
				if (force_stop) begin
					state_next = run_ctl_pkg::ST_IDLE;
				end
			end
			run_ctl_pkg::ST_PAR_MULTI: begin
				if (force_stop) begin
					state_next = run_ctl_pkg::ST_IDLE;
				end else if (terminate_cmd) begin
					state_next = run_ctl_pkg::ST_NORMAL;
				end
			end
			run_ctl_pkg::ST_PAR_ONE: begin
				// One command ends the space-entered session
				if (force_stop) begin
					state_next = run_ctl_pkg::ST_IDLE;
				end else if (one_cmd_seen_reg && cmd_done) begin
					state_next = run_ctl_pkg::ST_NORMAL;
				end
			end
			default: begin
				state_next = run_ctl_pkg::ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_reg <= run_ctl_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Run level to the target, stalled only by host access units
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			target_run <= 1'b0;
		end else begin
			target_run <= (state_next != run_ctl_pkg::ST_IDLE)
				&& !(acc_busy_reg && (unit_left_reg <= 5'h01 || acc_left_reg <= 5'h01));
		end
	end

	// ----------------------------------------------------------------
	// Cycle reset period and target reset
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			period_reg <= '0;
			tick_reg <= '0;
		end else if (state_reg == run_ctl_pkg::ST_IDLE && run_cmd && run_period_opt) begin
			period_reg <= run_period;
			tick_reg <= '0;
		end else if (period_hit) begin
			tick_reg <= '0;
		end else if (state_reg == run_ctl_pkg::ST_CYCLE) begin
			tick_reg <= tick_reg + 1'b1;
		end
	end

	// Reset pulse width counter
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rst_cnt_reg <= '0;
		end else if (period_hit) begin
			rst_cnt_reg <= 8'(run_ctl_pkg::RESET_PULSE_CYC);
		end else if (rst_cnt_reg != '0) begin
			rst_cnt_reg <= rst_cnt_reg - 1'b1;
		end
	end

	// Reset line is registered from period_hit and its own counter, without the break term
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			target_reset_line <= 1'b0;
		end else begin
			target_reset_line <= period_hit || (rst_cnt_reg > 8'h01);
		end
	end

	// ----------------------------------------------------------------
	// Trigger output, active low
	// ----------------------------------------------------------------
	// A break and a reset pulse never coincide since breaks are masked
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			trg_cnt_reg <= '0;
		end else if (period_hit) begin
			trg_cnt_reg <= 8'(run_ctl_pkg::RESET_PULSE_CYC);
		end else if (halt_pulse) begin
			trg_cnt_reg <= 8'(run_ctl_pkg::HALT_PULSE_CYC);
		end else if (trg_cnt_reg != '0) begin
			trg_cnt_reg <= trg_cnt_reg - 1'b1;
		end
	end

	// Registered trigger, low with each reset pulse and for each halting break
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			trigger_out_n <= 1'b1;
		end else begin
			trigger_out_n <= !(period_hit || halt_pulse || (trg_cnt_reg > 8'h01));
		end
	end

	// ----------------------------------------------------------------
	// Bus connection and arbitration
	// ----------------------------------------------------------------
	// No wait states ever: target_wait stays low while running
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			target_wait <= 1'b0;
		end else begin
			target_wait <= 1'b0;
		end
	end

	// Memory select by chip-select area; conflict blocks both
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			user_bus_sel <= 1'b0;
			emu_bus_sel <= 1'b0;
			direct_bus <= 1'b0;
			map_conflict <= 1'b0;
		end else begin
			map_conflict <= conflict;
			direct_bus <= running && !gate_mode;
			// Gate mode picks one memory per access
			user_bus_sel <= running && target_bus_cyc && !conflict && |(target_cs & user_cs_map);
			emu_bus_sel <= running && target_bus_cyc && !conflict && |(target_cs & emu_cs_map);
		end
	end

	// ----------------------------------------------------------------
	// Trace acquisition gating
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			trace_frozen_reg <= 1'b0;
		end else if (freeze_now) begin
			trace_frozen_reg <= 1'b1;
		end else if (state_next == run_ctl_pkg::ST_NORMAL && state_reg != run_ctl_pkg::ST_NORMAL) begin
			trace_frozen_reg <= 1'b0;
		end
	end

	// Trace-related command in space mode pauses capture
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			trace_cmd_reg <= 1'b0;
			one_cmd_seen_reg <= 1'b0;
		end else if (state_reg != run_ctl_pkg::ST_PAR_ONE) begin
			trace_cmd_reg <= 1'b0;
			one_cmd_seen_reg <= 1'b0;
		end else if (cmd_start) begin
			trace_cmd_reg <= cmd_is_trace;
			one_cmd_seen_reg <= 1'b1;
		end else if (cmd_done) begin
			trace_cmd_reg <= 1'b0;
		end
	end

	// Cache accesses are dropped from trace when disabled
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			trace_enable <= 1'b0;
		end else begin
			trace_enable <= running && !trace_frozen_reg && !freeze_now && !trace_cmd_reg
				&& !(cache_trace_dis && target_cache_acc);
		end
	end

	// ----------------------------------------------------------------
	// Parallel status and PC report
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			parallel_active <= 1'b0;
			pc_report_valid <= 1'b0;
			pc_report <= '0;
		end else begin
			parallel_active <= (state_next == run_ctl_pkg::ST_PAR_MULTI) || (state_next == run_ctl_pkg::ST_PAR_ONE);
			pc_report_valid <= 1'b0;
			if ((state_reg == run_ctl_pkg::ST_PAR_MULTI || state_reg == run_ctl_pkg::ST_PAR_ONE)
				&& state_next == run_ctl_pkg::ST_NORMAL) begin
				pc_report_valid <= 1'b1;
				pc_report <= target_pc;
			end
		end
	end

	// ----------------------------------------------------------------
	// Host memory access in parallel mode
	// ----------------------------------------------------------------
	// Each unit costs one halt cycle; the target resumes between units
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			acc_busy_reg <= 1'b0;
			acc_left_reg <= '0;
			acc_unit_reg <= '0;
			unit_left_reg <= '0;
			host_acc_done <= 1'b0;
		end else begin
			host_acc_done <= 1'b0;
			if (!acc_busy_reg) begin
				if (host_acc_req && parallel_active && host_acc_bytes != '0) begin
					acc_busy_reg <= 1'b1;
					acc_left_reg <= host_acc_bytes;
					unit_left_reg <= unit_size;
					acc_unit_reg <= unit_size;
				end
			end else if (acc_left_reg <= 5'h01 || unit_left_reg <= 5'h01) begin
				if (acc_left_reg <= 5'h01) begin
					acc_busy_reg <= 1'b0;
					host_acc_done <= 1'b1;
				end
				acc_left_reg <= acc_left_reg - 1'b1;
				unit_left_reg <= acc_unit_reg;
			end else begin
				acc_left_reg <= acc_left_reg - 1'b1;
				unit_left_reg <= unit_left_reg - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// [tb/run_ctl_target_model.sv]
// Target model: program counter, bus cycles and cache activity of the target
`default_nettype none
module target_model (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic target_run,
	input wire logic target_reset_line,
	input wire logic cache_on,
	output logic target_bus_cyc,
	output logic target_cache_acc,
	output logic [3:0] target_cs,
	output logic [31:0] target_pc
);
	// --------------------------------------------------------------
	// Program flow
	// --------------------------------------------------------------
	// Restart from the reset vector while reset is held; areas rotate one-hot
	always_ff @(posedge sys_clk) begin
		if (srst || target_reset_line) begin
			target_pc <= 32'h0000_0000;
			target_cs <= 4'h1;
		end else if (target_run) begin
			target_pc <= target_pc + 32'h0000_0002;
			target_cs <= {target_cs[2:0], target_cs[3]};
		end
	end
	// Bus cycles every other clock while running, so idle gaps are seen too
	always_ff @(posedge sys_clk) begin
		target_bus_cyc <= target_run && !target_bus_cyc;
		target_cache_acc <= target_run && cache_on;
	end
endmodule
`default_nettype wire

// [tb/run_ctl_checker.sv]
// Checker: port-level timing of the emulation run-control block
`default_nettype none
module run_ctl_checker (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic run_cmd,
	input wire logic run_period_opt,
	input wire logic [run_ctl_pkg::PERIOD_W-1:0] run_period,
	input wire logic force_stop,
	input wire logic key_return,
	input wire logic key_space,
	input wire logic trace_stop,
	input wire logic terminate_cmd,
	input wire logic hw_break,
	input wire logic sw_break,
	input wire logic target_run,
	input wire logic target_reset_line,
	input wire logic trigger_out_n,
	input wire logic target_wait,
	input wire logic trace_enable,
	input wire logic parallel_active,
	input wire logic pc_report_valid
);
	// --------------------------------------------------------------
	// Mode tracking
	// --------------------------------------------------------------
	logic cyc_reg; // Run started with period option
	logic seen_reg; // A reset pulse was already seen in this run
	logic [run_ctl_pkg::PERIOD_W:0] gap_reg; // Cycles since last reset rise, one bit wider so it cannot wrap
	logic [run_ctl_pkg::PERIOD_W-1:0] per_reg; // Period captured with the run
	logic brk; // Any break event
	assign brk = hw_break || sw_break;
	// Mode and period follow an accepted run command
	always_ff @(posedge sys_clk) begin
		if (srst || force_stop) begin
			cyc_reg <= 1'b0;
		end else if (run_cmd && !target_run) begin
			cyc_reg <= run_period_opt;
			per_reg <= run_period;
		end
	end
	// First rise only arms the period check
	always_ff @(posedge sys_clk) begin
		if (srst || force_stop) begin
			seen_reg <= 1'b0;
		end else if ($rose(target_reset_line)) begin
			seen_reg <= 1'b1;
		end
	end
	always_ff @(posedge sys_clk) begin
		gap_reg <= $rose(target_reset_line) ? '0 : gap_reg + 1'b1;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	a_no_wait_states: assert property (target_wait == 1'b0)
		else $error("wait state inserted");
	a_run_plain_normal: assert property (run_cmd && !run_period_opt && !target_run |=> target_run && !target_reset_line)
		else $error("plain run did not start normally");
	a_break_one_pulse: assert property (brk && target_run && !parallel_active && !cyc_reg
		|=> !target_run ##0 (!trigger_out_n)[*4] ##1 trigger_out_n)
		else $error("break halt or trigger pulse wrong");
	a_reset_with_trigger: assert property (cyc_reg |-> $rose(target_reset_line) == $fell(trigger_out_n))
		else $error("reset and trigger not together");
	a_reset_period_gap: assert property ($rose(target_reset_line) && seen_reg |-> gap_reg == {1'b0, per_reg})
		else $error("cycle reset period wrong");
	a_cycle_break_ignored: assert property (brk && cyc_reg && target_run |=> target_run)
		else $error("break taken in cycle reset");
	a_par_multi_entry: assert property ((key_return || trace_stop) && !key_space && target_run && !parallel_active
		&& !cyc_reg |=> parallel_active && target_run && !trace_enable)
		else $error("parallel entry by return or trace stop wrong");
	a_par_space_entry: assert property (key_space && target_run && !parallel_active && !cyc_reg
		|=> parallel_active && target_run)
		else $error("parallel entry by space wrong");
	a_par_refused_cycle: assert property ((key_return || key_space || trace_stop) && cyc_reg |=> !parallel_active)
		else $error("parallel entered in cycle reset");
	a_leave_with_report: assert property (terminate_cmd && parallel_active && !trace_enable
		|=> pc_report_valid && !parallel_active ##1 trace_enable && !pc_report_valid)
		else $error("terminate did not report and resume trace");
	c_cycle_period: cover property ($rose(target_reset_line) && seen_reg);
	c_pc_report: cover property (pc_report_valid);
	c_break_pulse: cover property ($fell(trigger_out_n) && !cyc_reg);
endmodule
`default_nettype wire

// [tb/test_emulation_run_control.sv]
// Testbench: run-control modes driven through console pulses
`default_nettype none
module test_emulation_run_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, srst, run_cmd, run_period_opt, force_stop, key_return, key_space, terminate_cmd, cmd_start;
	logic cmd_is_trace, cmd_done, host_acc_req, gate_mode, cache_trace_dis, hw_break, sw_break, trace_stop;
	logic target_cache_acc, target_bus_cyc, cache_on, target_run, target_reset_line, trigger_out_n;
	logic target_wait, user_bus_sel, emu_bus_sel, direct_bus, map_conflict, trace_enable, parallel_active;
	logic pc_report_valid, host_acc_done;
	logic [run_ctl_pkg::PERIOD_W-1:0] run_period;
	logic [1:0] host_acc_kind;
	logic [4:0] host_acc_bytes;
	logic [3:0] user_cs_map, emu_cs_map, target_cs;
	logic [31:0] target_pc, pc_report;
	int n_fail, checks, n, m, halts;
	emulation_run_control i_emulation_run_control (.sys_clk, .srst, .run_cmd, .run_period_opt, .run_period,
		.force_stop, .key_return, .key_space, .terminate_cmd, .cmd_start, .cmd_is_trace, .cmd_done, .host_acc_req,
		.host_acc_kind, .host_acc_bytes, .gate_mode, .cache_trace_dis, .user_cs_map, .emu_cs_map, .hw_break,
		.sw_break, .trace_stop, .target_cache_acc, .target_bus_cyc, .target_cs, .target_pc, .target_run,
		.target_reset_line, .trigger_out_n, .target_wait, .user_bus_sel, .emu_bus_sel, .direct_bus, .map_conflict,
		.trace_enable, .parallel_active, .pc_report_valid, .pc_report, .host_acc_done);
	target_model i_target_model (.sys_clk, .srst, .target_run, .target_reset_line, .cache_on, .target_bus_cyc,
		.target_cache_acc, .target_cs, .target_pc);
	// 200 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic end_of_test;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %b expected %b", $time, got, exp);
		end
	endtask
	task automatic step(input int c);
		repeat (c) @(posedge sys_clk);
		#1;
	endtask
	// One-cycle console pulse, raised and dropped on falling edges
	task automatic pulse(input int k);
		@(negedge sys_clk);
		case (k)
			0: run_cmd = 1'b1;
			1: force_stop = 1'b1;
			2: key_return = 1'b1;
			3: key_space = 1'b1;
			4: terminate_cmd = 1'b1;
			5: cmd_start = 1'b1;
			6: cmd_done = 1'b1;
			7: host_acc_req = 1'b1;
			8: hw_break = 1'b1;
			9: sw_break = 1'b1;
			default: trace_stop = 1'b1;
		endcase
		@(negedge sys_clk);
		{run_cmd, force_stop, key_return, key_space, terminate_cmd, cmd_start} = '0;
		{cmd_done, host_acc_req, hw_break, sw_break, trace_stop} = '0;
	endtask
	// Bounded wait for an output event; also notes any target halt seen
	task automatic waitfor(input int k);
		n = 0;
		while ((k == 0 ? !trigger_out_n : k == 1 ? host_acc_done : k == 2 ? pc_report_valid : target_reset_line) !== 1'b1) begin
			step(1);
			n++;
			if (target_run === 1'b0) halts++;
			if (n > 400) begin
				n_fail++;
				$display("[ERR] %0t wait timed out", $time);
				end_of_test();
			end
		end
	endtask
	initial begin
		{run_cmd, force_stop, key_return, key_space, terminate_cmd, cmd_start, cmd_done} = '0;
		{host_acc_req, hw_break, sw_break, trace_stop, cache_trace_dis, cache_on, cmd_is_trace} = '0;
		{srst, gate_mode, run_period_opt, n_fail, checks, halts} = {3'b110, 96'h0};
		run_period = 24'h00_0028;
		host_acc_kind = run_ctl_pkg::ACC_DUMP;
		host_acc_bytes = run_ctl_pkg::UNIT_DUMP;
		user_cs_map = 4'h1;
		emu_cs_map = 4'h2;
		repeat (4) @(negedge sys_clk);
		srst = 1'b0;
		step(1);
		chk(trigger_out_n, 1'b1);
		// Each break kind halts with a four-cycle trigger pulse
		for (int k = 8; k < 10; k++) begin
			pulse(0);
			step(2);
			chk(target_run, 1'b1);
			chk(target_wait, 1'b0);
			pulse(k);
			waitfor(0);
			chk(target_run, 1'b0);
			m = 0;
			while (!trigger_out_n && m < 9) begin
				step(1);
				m++;
			end
			chk(m == 4, 1'b1);
		end
		// Gate insertion versus direct bus, then an overlapping area
		pulse(0);
		step(2);
		chk(direct_bus, 1'b0);
		chk(map_conflict, 1'b0);
		// Bus cycles alternate, so one memory is picked twice in eight cycles
		m = 0;
		repeat (8) begin
			step(1);
			m += user_bus_sel + emu_bus_sel;
		end
		chk(m == 2, 1'b1);
		@(negedge sys_clk);
		{gate_mode, emu_cs_map, cache_on, cache_trace_dis} = {1'b0, 4'h3, 2'b11};
		step(3);
		chk(direct_bus, 1'b1);
		chk(map_conflict, 1'b1);
		chk(user_bus_sel | emu_bus_sel, 1'b0);
		chk(trace_enable, 1'b0);
		@(negedge sys_clk);
		cache_trace_dis = 1'b0;
		step(3);
		chk(trace_enable, 1'b1);
		// Parallel mode by return and by trace stop, with a dump and a disassembly access
		for (int i = 0; i < 2; i++) begin
			pulse(i == 0 ? 2 : 10);
			// Dump of one 16-byte unit, then disassembly of two 4-byte units
			{host_acc_kind, host_acc_bytes} = (i == 0) ? {run_ctl_pkg::ACC_DUMP, run_ctl_pkg::UNIT_DUMP}
				: {run_ctl_pkg::ACC_DIS, 5'h08};
			step(1);
			chk(parallel_active & target_run, 1'b1);
			chk(trace_enable, 1'b0);
			halts = 0;
			pulse(7);
			waitfor(1);
			chk(n == host_acc_bytes && halts == (i == 0 ? 1 : 2), 1'b1);
			chk(parallel_active, 1'b1);
			pulse(4);
			waitfor(2);
			chk(target_pc - pc_report < 32'h0000_0008, 1'b1);
			step(1);
			chk(trace_enable & !parallel_active, 1'b1);
		end
		// Space entry: one trace command, then back to normal
		pulse(3);
		step(1);
		chk(parallel_active & trace_enable, 1'b1);
		@(negedge sys_clk);
		cmd_is_trace = 1'b1;
		pulse(5);
		step(2);
		chk(trace_enable, 1'b0);
		pulse(6);
		step(2);
		chk(!parallel_active & trace_enable, 1'b1);
		// Cycle reset: pulse width, period, an ignored hardware break and return key
		pulse(1);
		run_period_opt = 1'b1;
		pulse(0);
		run_period_opt = 1'b0;
		waitfor(3);
		chk(trigger_out_n, 1'b0);
		m = 0;
		while (target_reset_line && m < 60) begin
			step(1);
			m++;
		end
		chk(m == 20, 1'b1);
		waitfor(3);
		chk(m + n == 41, 1'b1);
		step(22);
		pulse(8);
		pulse(2);
		step(2);
		chk(target_run & !parallel_active, 1'b1);
		pulse(1);
		step(2);
		chk(target_run, 1'b0);
		end_of_test();
	end
endmodule
bind emulation_run_control run_ctl_checker i_run_ctl_checker (.sys_clk, .srst, .run_cmd, .run_period_opt,
	.run_period, .force_stop, .key_return, .key_space, .trace_stop, .terminate_cmd, .hw_break, .sw_break,
	.target_run, .target_reset_line, .trigger_out_n, .target_wait, .trace_enable, .parallel_active,
	.pc_report_valid);
`default_nettype wire
